// File: logic/sdl_ctrl.sv
// Controller end: AHB-Lite registers driving the programming link
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module sdl_ctrl (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Programming link
    sdl_link_if.ctrl         link
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOW, ST_HIGH, ST_LOAD, ST_UNLOAD
    } sdl_state_t;

    sdl_state_t  state_ff;
    logic [31:0] ctrl_ff;
    logic        wr_ff;
    logic [7:0]  addr_ff;
    logic [10:0] frame_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  tmr_ff;
    logic        go;
    logic        busy;

    assign busy = (state_ff != ST_IDLE);

    // ------------------------------------------------------------
    // Bus slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff   <= 1'b0;
            addr_ff <= 8'h00;
        end else if (hready) begin
            wr_ff   <= hsel && hwrite && htrans == sdl_pkg::HTRANS_NONSEQ;
            addr_ff <= haddr;
        end
    end

    assign go = wr_ff && addr_ff == sdl_pkg::REG_CTRL
                && hwdata[sdl_pkg::CTRL_GO_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= sdl_pkg::CTRL_RESET_VAL;
        end else if (wr_ff && addr_ff == sdl_pkg::REG_CTRL) begin
            ctrl_ff <= hwdata;
            ctrl_ff[sdl_pkg::CTRL_GO_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (hready && hsel && !hwrite
                     && htrans == sdl_pkg::HTRANS_NONSEQ) begin
            if (haddr == sdl_pkg::REG_CTRL) begin
                hrdata <= ctrl_ff;
            end else if (haddr == sdl_pkg::REG_STATUS) begin
                hrdata <= {31'h0000_0000, busy};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Static pins
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.parallel_load_strobe_n  <= 1'b0;
            link.loop_divider_inputs     <= 9'h000;
            link.master_reset_pin        <= 1'b0;
            link.reference_source_select <= 1'b1;
        end else begin
            // Parallel mode follows the value directly R01 R02 R04
            link.parallel_load_strobe_n  <= ctrl_ff[sdl_pkg::CTRL_SER_BIT];
            link.loop_divider_inputs     <= ctrl_ff[8:0];
            link.master_reset_pin        <= ctrl_ff[sdl_pkg::CTRL_MR_BIT];
            link.reference_source_select <=
                ctrl_ff[sdl_pkg::CTRL_REFSEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Serial frame engine: null, select, 9 bits MSB first
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff          <= ST_IDLE;
            frame_ff          <= sdl_pkg::FRAME_RESET_VAL;
            bit_ff            <= 4'h0;
            tmr_ff            <= 8'h00;
            link.serial_clock <= 1'b0;
            link.serial_data  <= 1'b0;
            link.serial_load  <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // Go only counts in serial mode R06
                    if (go && hwdata[sdl_pkg::CTRL_SER_BIT]) begin
                        frame_ff <= {1'b0, // R13 R20
                            hwdata[sdl_pkg::CTRL_SEL_BIT], hwdata[8:0]};
                        bit_ff   <= 4'h0;
                        tmr_ff   <= sdl_pkg::SCLK_HALF;
                        state_ff <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    link.serial_load <= 1'b0; // R06
                    link.serial_data <= frame_ff[10];
                    if (tmr_ff == 8'h00) begin
                        link.serial_clock <= 1'b1;
                        tmr_ff   <= sdl_pkg::SCLK_HALF;
                        state_ff <= ST_HIGH;
                    end else begin
                        tmr_ff <= tmr_ff - 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (tmr_ff == 8'h00) begin
                        link.serial_clock <= 1'b0;
                        frame_ff <= {frame_ff[9:0], 1'b0};
                        tmr_ff   <= sdl_pkg::SCLK_HALF;
                        bit_ff   <= bit_ff + 4'h1;
                        state_ff <= (bit_ff == 4'(sdl_pkg::FRAME_W - 1))
                                    ? ST_LOAD : ST_LOW;
                    end else begin
                        tmr_ff <= tmr_ff - 8'h01;
                    end
                end
                ST_LOAD: begin
                    if (tmr_ff == 8'h00) begin
                        link.serial_load <= 1'b1; // R08
                        tmr_ff   <= sdl_pkg::SCLK_HALF;
                        state_ff <= ST_UNLOAD;
                    end else begin
                        tmr_ff <= tmr_ff - 8'h01;
                    end
                end
                ST_UNLOAD: begin
                    if (tmr_ff == 8'h00) begin
                        link.serial_load <= 1'b0; // R09
                        state_ff <= ST_IDLE;
                    end else begin
                        tmr_ff <= tmr_ff - 8'h01;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : sdl_ctrl

// File: logic/sdl_device.sv
// Device end: divider load logic, reference divider and output divider
// Operation
// R01: Strobe low passes parallel inputs straight through
// R02: Strobe rising captures parallel inputs
// R03: Captured value held until strobe low/serial
// R04: Board may strap parallel inputs for default
// R05: Parallel path forces output divide by two
// R06: Serial only with strobe high, load low
// R07: Serial clock rising shifts data in
// R08: Load rising transfers shift register out
// R09: Load falling latches divider values
// R10: Load high passes serial data per clock
// R11: Select 0 divides by 2, 1 by 4
// R12: Output select changed only serially
// R13: Controller leaves null slot empty
// R14: Reference is selected input divided by sixteen
// R15: Oscillator equals twice loop value times reference
// R16: Controller keeps loop value 125 to 350; sdl_ctrl passes any 9-bit value unchecked
// R17: Output divider gives 50% duty
// R18: Master reset clears dividers, keeps loop value
// R19: Reference select high crystal, low test
// R20: Frame: null, select, loop bits MSB first
`timescale 1ns/1ps
module sdl_device (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Programming link
    sdl_link_if.device      link,
    // Reference sources
    input  wire logic       xtal_clk,
    input  wire logic       test_clk,
    // Status and outputs
    output logic [8:0]      loop_value,
    output logic            out_sel,
    output logic            ref_pulse,
    output logic            vco_tick,
    output logic            clock_output
);
    // ------------------------------------------------------------
    // Edge detection on the pins
    // ------------------------------------------------------------
    logic        pl_ff;
    logic        sl_ff;
    logic        sc_ff;
    logic [10:0] shift_ff;
    logic [10:0] nxt_shift;
    logic        from_par_ff;
    logic        ref_src;
    logic [3:0]  ref_cnt_ff;
    logic [9:0]  vco_cnt_ff;
    logic        ref_en;
    logic        sclk_rise;
    logic        ser_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pl_ff <= 1'b0;
            sl_ff <= 1'b0;
            sc_ff <= 1'b0;
        end else begin
            pl_ff <= link.parallel_load_strobe_n;
            sl_ff <= link.serial_load;
            sc_ff <= link.serial_clock;
        end
    end

    assign sclk_rise = link.serial_clock & ~sc_ff;
    assign ser_mode  = link.parallel_load_strobe_n; // R06
    assign nxt_shift = {shift_ff[9:0], link.serial_data};

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_ff <= sdl_pkg::FRAME_RESET_VAL;
        end else if (ser_mode && sclk_rise) begin
            shift_ff <= nxt_shift; // R07 R20
        end
    end

    // ------------------------------------------------------------
    // Loop divider value and output select
    // Master reset leaves these alone on purpose
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_value <= sdl_pkg::LOOP_RESET_VAL;
        end else if (!link.parallel_load_strobe_n) begin
            loop_value <= link.loop_divider_inputs; // R01 R18
        end else if (!pl_ff) begin
            loop_value <= link.loop_divider_inputs; // R02 R03
        end else if (link.serial_load && !sl_ff) begin
            loop_value <= shift_ff[8:0]; // R08
        end else if (link.serial_load && sclk_rise) begin
            loop_value <= nxt_shift[8:0]; // R10
        end
        // Falling load: nothing updates, value stays latched R09
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            from_par_ff <= 1'b1;
            out_sel     <= sdl_pkg::OUT_DIV2;
        end else if (!link.parallel_load_strobe_n || !pl_ff) begin
            from_par_ff <= 1'b1;
            out_sel     <= sdl_pkg::OUT_DIV2; // R05 R12
        end else if (link.serial_load && !sl_ff) begin
            from_par_ff <= 1'b0;
            out_sel     <= shift_ff[sdl_pkg::FRAME_SEL_POS]; // R08
        end else if (link.serial_load && sclk_rise) begin
            from_par_ff <= 1'b0;
            out_sel     <= nxt_shift[sdl_pkg::FRAME_SEL_POS]; // R10
        end
    end

    // ------------------------------------------------------------
    // Reference: chosen source divided by sixteen
    // Sources are sampled as synchronous levels; hclk must be faster
    // ------------------------------------------------------------
    logic src_ff;

    assign ref_src = link.reference_source_select ? xtal_clk
                                                  : test_clk; // R19
    assign ref_en  = ref_src & ~src_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_ff     <= 1'b0;
            ref_cnt_ff <= 4'h0;
            ref_pulse  <= 1'b0;
        end else if (link.master_reset_pin) begin
            src_ff     <= ref_src;
            ref_cnt_ff <= 4'h0; // R18
            ref_pulse  <= 1'b0;
        end else begin
            src_ff    <= ref_src;
            ref_pulse <= ref_en && (ref_cnt_ff == sdl_pkg::REF_LAST);
            if (ref_en) begin
                ref_cnt_ff <= ref_cnt_ff + 4'h1; // R14
            end
        end
    end

    // ------------------------------------------------------------
    // Oscillator model: 2M ticks per reference period
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vco_cnt_ff <= 10'h000;
            vco_tick   <= 1'b0;
        end else if (link.master_reset_pin || ref_pulse) begin
            vco_cnt_ff <= {loop_value, 1'b0}; // R15
            vco_tick   <= 1'b0;
        end else if (vco_cnt_ff != 10'h000) begin
            vco_cnt_ff <= vco_cnt_ff - 10'h001;
            vco_tick   <= 1'b1;
        end else begin
            vco_tick   <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output divider
    // ------------------------------------------------------------
    sdl_out_div u_out_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .en      (vco_tick),
        .div_rst (link.master_reset_pin),
        .sel     (out_sel & ~from_par_ff), // R05
        .q       (clock_output)
    );
endmodule : sdl_device

// File: logic/sdl_link_if.sv
// Interface: programming pins between controller and synthesizer
`timescale 1ns/1ps
interface sdl_link_if;
    logic       parallel_load_strobe_n;
    logic [8:0] loop_divider_inputs;
    logic       serial_clock;
    logic       serial_data;
    logic       serial_load;
    logic       master_reset_pin;
    logic       reference_source_select;

    modport device (
        input parallel_load_strobe_n,
        input loop_divider_inputs,
        input serial_clock,
        input serial_data,
        input serial_load,
        input master_reset_pin,
        input reference_source_select
    );
    modport ctrl (
        output parallel_load_strobe_n,
        output loop_divider_inputs,
        output serial_clock,
        output serial_data,
        output serial_load,
        output master_reset_pin,
        output reference_source_select
    );
endinterface : sdl_link_if

// File: logic/sdl_out_div.sv
// Output divider: 50% duty divide by 2 or 4, with reset
`timescale 1ns/1ps
module sdl_out_div (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Control
    input  wire logic en,
    input  wire logic div_rst,
    input  wire logic sel,
    // Output
    output logic      q
);
    logic [1:0] cnt_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 2'h0;
        end else if (div_rst) begin
            cnt_ff <= 2'h0; // R18
        end else if (en) begin
            cnt_ff <= cnt_ff + 2'h1;
        end
    end

    // Div2 toggles each enable, div4 each second: both 50% duty
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= 1'b0;
        end else if (div_rst) begin
            q <= 1'b0; // R18
        end else if (en) begin
            if (sel == sdl_pkg::OUT_DIV2 || cnt_ff[0]) begin
                q <= ~q; // R11 R17
            end
        end
    end
endmodule : sdl_out_div

// File: logic/sdl_pkg.sv
// Package: constants shared by both ends of the divider load link
package sdl_pkg;
    // Frame and divider widths
    localparam int LOOP_W          = 9;
    localparam int FRAME_W         = 11;
    localparam int FRAME_SEL_POS   = 9;
    localparam logic [8:0] LOOP_RESET_VAL = 9'h000;
    localparam logic [10:0] FRAME_RESET_VAL = 11'h000;
    // Reference pre-divider and loop multiplier
    localparam int REF_DIV         = 16;
    localparam int REF_CNT_W       = 4;
    localparam int VCO_MULT        = 2;
    localparam logic [3:0] REF_HALF_TERM = 4'h7;
    localparam logic [3:0] REF_LAST    = 4'hF;
    // Output divider select encodings
    localparam logic OUT_DIV2      = 1'b0;
    localparam logic OUT_DIV4      = 1'b1;
    // Lock range for a 16 MHz reference
    localparam logic [8:0] LOOP_MIN = 9'h07D;
    localparam logic [8:0] LOOP_MAX = 9'h15E;
    // Controller: serial clock half period minus one, in hclk cycles
    localparam logic [7:0] SCLK_HALF = 8'h04;
    // Controller register offsets (AHB-Lite byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    // Control register fields
    localparam int CTRL_VAL_LSB   = 0;
    localparam int CTRL_SEL_BIT   = 9;
    localparam int CTRL_SER_BIT   = 10;
    localparam int CTRL_GO_BIT    = 11;
    localparam int CTRL_MR_BIT    = 12;
    localparam int CTRL_REFSEL_BIT = 13;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_2000;
    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : sdl_pkg

// File: tb/sdl_link_checker.sv
// Checker: timing relations on the programming link and device outputs
`timescale 1ns/1ps
module sdl_link_checker (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Programming link
    input wire logic       parallel_load_strobe_n,
    input wire logic [8:0] loop_divider_inputs,
    input wire logic       serial_clock,
    input wire logic       serial_data,
    input wire logic       serial_load,
    input wire logic       master_reset_pin,
    // Device outputs
    input wire logic [8:0] loop_value,
    input wire logic       out_sel,
    input wire logic       clock_output
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------
    // Parallel path
    // ----------------------------------------
    property p_pass;
        !$past(parallel_load_strobe_n)
            |-> loop_value == $past(loop_divider_inputs);
    endproperty
    a_pass: assert property (p_pass)
        else $error("loop value does not follow parallel inputs");
    property p_div2;
        !$past(parallel_load_strobe_n) |-> out_sel == sdl_pkg::OUT_DIV2;
    endproperty
    a_div2: assert property (p_div2)
        else $error("parallel path left divide by four");
    property p_capture;
        $rose(parallel_load_strobe_n) && $stable(loop_divider_inputs)
            |=> loop_value == $past(loop_divider_inputs, 2);
    endproperty
    a_capture: assert property (p_capture)
        else $error("strobe rise did not capture inputs");
    // Two cycles of margin so a late capture is not flagged
    property p_hold;
        parallel_load_strobe_n && $past(parallel_load_strobe_n)
            && $past(parallel_load_strobe_n, 2) && !serial_load
            && !$past(serial_load)
            |-> $stable(loop_value) && $stable(out_sel);
    endproperty
    a_hold: assert property (p_hold)
        else $error("divider values moved while held");
    property p_mr;
        master_reset_pin && $past(master_reset_pin) |-> !clock_output;
    endproperty
    a_mr: assert property (p_mr)
        else $error("output not low under master reset");

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    property p_sclk_hi;
        $rose(serial_clock) |-> serial_clock [*5] ##1 !serial_clock;
    endproperty
    a_sclk_hi: assert property (p_sclk_hi)
        else $error("serial clock high phase wrong");
    property p_sclk_lo;
        $fell(serial_clock) |-> !serial_clock [*5];
    endproperty
    a_sclk_lo: assert property (p_sclk_lo)
        else $error("serial clock low phase too short");
    property p_data;
        serial_clock && $past(serial_clock) |-> $stable(serial_data);
    endproperty
    a_data: assert property (p_data)
        else $error("serial data moved while clock high");
    property p_mode;
        serial_clock |-> parallel_load_strobe_n && !serial_load;
    endproperty
    a_mode: assert property (p_mode)
        else $error("shifting outside serial mode");
    property p_load;
        $rose(serial_load) |-> serial_load [*5] ##1 !serial_load;
    endproperty
    a_load: assert property (p_load)
        else $error("load pulse length wrong");
endmodule // sdl_link_checker

// File: tb/synth_divider_load_interface_test.sv
// Testbench: AHB-Lite controller driving the divider load device
`timescale 1ns/1ps
module synth_divider_load_interface_test;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        xtal_clk;
    logic        test_clk;
    logic [8:0]  loop_value;
    logic        out_sel;
    logic        ref_pulse;
    logic        vco_tick;
    logic        clock_output;
    logic [10:0] frame_ff;
    logic [31:0] rd;
    int          miscompares;
    int          n_tests;
    int          h2, l2, h4, l4, g, t;

    sdl_link_if u_sdl_link_if ();
    sdl_ctrl u_sdl_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(u_sdl_link_if));
    sdl_device u_sdl_device (.hclk(hclk), .hresetn(hresetn),
        .link(u_sdl_link_if), .xtal_clk(xtal_clk), .test_clk(test_clk),
        .loop_value(loop_value), .out_sel(out_sel), .ref_pulse(ref_pulse),
        .vco_tick(vco_tick), .clock_output(clock_output));
    sdl_link_checker u_sdl_link_checker (.hclk(hclk), .hresetn(hresetn),
        .parallel_load_strobe_n(u_sdl_link_if.parallel_load_strobe_n),
        .loop_divider_inputs(u_sdl_link_if.loop_divider_inputs),
        .serial_clock(u_sdl_link_if.serial_clock),
        .serial_data(u_sdl_link_if.serial_data),
        .serial_load(u_sdl_link_if.serial_load),
        .master_reset_pin(u_sdl_link_if.master_reset_pin),
        .loop_value(loop_value), .out_sel(out_sel),
        .clock_output(clock_output));

    // ----------------------------------------
    // Clocks: sources stay off the hclk rising edges
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        xtal_clk = 1'b0;
        forever #300 xtal_clk = ~xtal_clk;
    end
    initial begin
        test_clk = 1'b0;
        forever #500 test_clk = ~test_clk;
    end
    always @(posedge u_sdl_link_if.serial_clock) begin
        frame_ff <= {frame_ff[9:0], u_sdl_link_if.serial_data};
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] cw(logic rs, logic mr, logic go,
                                       logic ser, logic s, logic [8:0] v);
        return {18'h0, rs, mr, go, ser, s, v};
    endfunction
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= sdl_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk_val(input logic [31:0] e, input logic [31:0] a);
        n_tests++;
        if (a !== e) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic chk_int(input int e, input int a);
        n_tests++;
        if (a !== e) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic wait_idle(input logic [8:0] v, input logic s);
        repeat (2) @(posedge hclk);
        do xfer(sdl_pkg::REG_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
        repeat (2) @(posedge hclk);
        chk_val({23'h0, v}, {23'h0, loop_value});
        chk_val({31'h0, s}, {31'h0, out_sel});
        chk_val({22'h0, s, v}, {22'h0, frame_ff[9:0]});
    endtask
    task automatic out_runs(output int h, output int l);
        h = 0;
        l = 0;
        // Start at a burst so the measured run is never its tail
        while (ref_pulse !== 1'b1) @(negedge hclk);
        while (clock_output !== 1'b0) @(negedge hclk);
        while (clock_output !== 1'b1) @(negedge hclk);
        while (clock_output === 1'b1) begin
            h++;
            @(negedge hclk);
        end
        while (clock_output === 1'b0) begin
            l++;
            @(negedge hclk);
        end
    endtask
    task automatic ref_gap(output int n, output int k);
        while (ref_pulse !== 1'b1) @(negedge hclk);
        n = 0;
        k = 0;
        do begin
            n++;
            @(negedge hclk);
            if (vco_tick === 1'b1) k++;
        end while (ref_pulse !== 1'b1);
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        frame_ff = 11'h000;
        miscompares = 0;
        n_tests = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(sdl_pkg::REG_CTRL, 1'b0, 32'h0);
        chk_val(sdl_pkg::CTRL_RESET_VAL, rd);
        chk_val(32'h0, {23'h0, loop_value});
        chk_val(32'h0, {31'h0, hresp});
        // Unmapped place reads zero and ignores writes
        xfer(8'h08, 1'b1, 32'hFFFF_FFFF);
        xfer(8'h08, 1'b0, 32'h0);
        chk_val(32'h0, rd);
        xfer(sdl_pkg::REG_CTRL, 1'b0, 32'h0);
        chk_val(sdl_pkg::CTRL_RESET_VAL, rd);
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 0, 0, 0, sdl_pkg::LOOP_MIN));
        repeat (4) @(posedge hclk);
        chk_val({23'h0, sdl_pkg::LOOP_MIN}, {23'h0, loop_value});
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 0, 0, 0, sdl_pkg::LOOP_MAX));
        repeat (4) @(posedge hclk);
        chk_val({23'h0, sdl_pkg::LOOP_MAX}, {23'h0, loop_value});
        // Capture, then inputs and select move with strobe high
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 0, 1, 0, sdl_pkg::LOOP_MAX));
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 0, 1, 1, 9'h0AA));
        repeat (4) @(posedge hclk);
        chk_val({23'h0, sdl_pkg::LOOP_MAX}, {23'h0, loop_value});
        chk_val(32'h0, {31'h0, out_sel});
        // Second go while busy must be ignored
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 1, 1, 1, 9'h15E));
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 1, 1, 0, 9'h07D));
        wait_idle(9'h15E, 1'b1);
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 1, 1, 0, 9'h0C8));
        wait_idle(9'h0C8, 1'b0);
        out_runs(h2, l2);
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 1, 1, 1, 9'h0C8));
        wait_idle(9'h0C8, 1'b1);
        out_runs(h4, l4);
        chk_int(h2, l2);
        chk_int(h4, l4);
        chk_int(2 * h2, h4);
        // Master reset silences output, keeps loop value
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 1, 0, 1, 1, 9'h0C8));
        repeat (5) @(posedge hclk);
        chk_val(32'h0, {31'h0, clock_output});
        chk_val(32'h0C8, {23'h0, loop_value});
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 0, 1, 1, 9'h0C8));
        // Back to parallel after a divide by four frame
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(1, 0, 0, 0, 0, sdl_pkg::LOOP_MIN));
        repeat (4) @(posedge hclk);
        chk_val(32'h0, {31'h0, out_sel});
        ref_gap(g, t);
        ref_gap(g, t);
        chk_int(sdl_pkg::REF_DIV * 60, g);
        chk_int(sdl_pkg::VCO_MULT * sdl_pkg::LOOP_MIN, t);
        xfer(sdl_pkg::REG_CTRL, 1'b1, cw(0, 0, 0, 0, 0, sdl_pkg::LOOP_MIN));
        ref_gap(g, t);
        ref_gap(g, t);
        chk_int(sdl_pkg::REF_DIV * 100, g);
        chk_int(sdl_pkg::VCO_MULT * sdl_pkg::LOOP_MIN, t);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        miscompares++;
        end_of_test();
    end
endmodule // synth_divider_load_interface_test
